/* File: core/sarr_dev.sv */
// converter end: conversion timing, result registers, parallel and serial readout
//
// Summary of operation
// - format pin picks offset or two's complement
// - parallel read keeps; bit clock shifts once
// - host reads parallel before external clock serial
// - internal clock start shifts previous result
// - external clock: conversion runs internally
// - external idle read shifts latest result
// - external read mid conversion: previous result
// - host releases a strobe before busy rises
// - busy ignores every convert command
// - two's complement code points
// - offset binary code points
// - parallel use: source high, clock low
// - bus driven only read high, select low
// - half select low upper, high lower
// - host may toggle half select
// - result invalid until first conversion
// - registers updated on the edge busy rises
// - start needs both strobes low 40ns
// - internal clock: 16 pulses MSB first
// - clock low after pulses, chain bit out
// - external clock duty 20-70%, up to 10MHz
`timescale 1ns/1ps
`default_nettype none
module sarr_dev
   import sarr_pkg::*;
#(
   parameter int CONV_CYCLES  = sarr_pkg::CONV_CYC,
   parameter int DELAY_CYCLES = sarr_pkg::ICLK_DELAY_CYC,
   parameter int HALF_CYCLES  = sarr_pkg::ICLK_HALF_CYC
) (
   sarr_if.dev                        LNK,
   input  wire logic                  I_RESET,
   input  wire logic                  I_CE,
   input  wire logic [sarr_pkg::RES_W-1:0] I_SAMPLE,
   output logic                       O_RESULT_VALID,
   output logic                       O_CONVERTING
);
   import sarr_pkg::*;
   ///////////////////////////////////////////////////////////////////////////////
   // declarations
   logic                 clk;
   logic [6:0]           pins_s;
   logic                 cs_n_s;
   logic                 rc_s;
   logic                 byte_s;
   logic                 fmt_s;
   logic                 src_s;
   logic                 sbc_s;
   logic                 tag_s;
   logic                 sbc_prev_ff;
   sarr_dev_st_t         st_ff;
   logic [CNT_W-1:0]     conv_cnt_ff;
   logic [RES_W-1:0]     held_ff;
   logic [RES_W-1:0]     result_ff;
   logic [RES_W-1:0]     shift_ff;
   logic                 valid_ff;
   logic                 busy_n_ff;
   sarr_iser_st_t        is_ff;
   logic [CNT_W-1:0]     is_cnt_ff;
   logic [BIT_CNT_W-1:0] is_bits_ff;
   logic                 iclk_ff;
   logic                 tag_ff;
   logic                 sbc_oe_n_ff;
   logic [HALF_W-1:0]    pbus_ff;
   logic                 pbus_oe_n_ff;
   logic                 start;
   logic                 conv_done;
   logic                 is_shift;
   logic                 is_end;
   logic                 ext_shift;
   logic [RES_W-1:0]     nxt_code;
   assign clk = LNK.link_clk;

   ///////////////////////////////////////////////////////////////////////////////
   // pin inputs arrive from the host domain
   sarr_sync #(.W(7)) u_sync (
      .i_clk (clk),
      .i_ce  (I_CE),
      .i_d   ({LNK.cs_n, LNK.rc, LNK.byte_sel, LNK.code_fmt,
               LNK.clk_src, LNK.sbc, LNK.tag}),
      .o_q   (pins_s)
   );
   assign {cs_n_s, rc_s, byte_s, fmt_s, src_s, sbc_s, tag_s} = pins_s;
   // strobes are or'ed and level triggered; busy blocks them
   assign start     = (st_ff == DV_IDLE) && !cs_n_s && !rc_s;
   assign conv_done = (st_ff == DV_CONV) &&
                      (conv_cnt_ff == CNT_W'(CONV_CYCLES - 1));

   // output code from the held straight binary sample
   assign nxt_code = fmt_s ? held_ff : (held_ff ^ SIGN_MASK);

   ///////////////////////////////////////////////////////////////////////////////
   // conversion state, counter and busy
   always_ff @(posedge clk) begin
      if (I_RESET) begin
         st_ff       <= DV_IDLE;
         conv_cnt_ff <= '0;
         busy_n_ff   <= 1'b1;
      end else if (I_CE) begin
         case (st_ff)
            DV_IDLE: begin
               if (start) begin
                  st_ff       <= DV_CONV;
                  conv_cnt_ff <= '0;
                  busy_n_ff   <= 1'b0;
               end
            end
            DV_CONV: begin
               if (conv_done) begin
                  st_ff     <= DV_IDLE;
                  busy_n_ff <= 1'b1;
               end else begin
                  conv_cnt_ff <= conv_cnt_ff + 1'b1;
               end
            end
            default: begin
               st_ff <= DV_IDLE;
            end
         endcase
      end
   end
   // sample and hold captures at start
   always_ff @(posedge clk) begin
      if (I_RESET) begin
         held_ff <= RES_RESET;
      end else if (I_CE && start) begin
         held_ff <= I_SAMPLE;
      end
   end

   // parallel result register, loaded the edge busy returns high
   always_ff @(posedge clk) begin
      if (I_RESET) begin
         result_ff <= RES_RESET;
         valid_ff  <= 1'b0;
      end else if (I_CE && conv_done) begin
         result_ff <= nxt_code;
         valid_ff  <= 1'b1;
      end
   end

   ///////////////////////////////////////////////////////////////////////////////
   // external bit clock edge, read mode selected
   always_ff @(posedge clk) begin
      if (I_RESET) begin
         sbc_prev_ff <= 1'b0;
      end else if (I_CE) begin
         sbc_prev_ff <= sbc_s;
      end
   end
   assign ext_shift = src_s && !cs_n_s && rc_s && sbc_s && !sbc_prev_ff;
   assign is_shift  = (is_ff == IS_LOW) && (is_cnt_ff == '0); // just after the fall
   assign is_end    = (is_ff == IS_LOW) && (is_cnt_ff == CNT_W'(HALF_CYCLES - 1));
   // serial shift register; a new result wins over any shift
   always_ff @(posedge clk) begin
      if (I_RESET) begin
         shift_ff <= RES_RESET;
      end else if (I_CE) begin
         if (conv_done) begin
            shift_ff <= nxt_code;
         end else if (is_shift) begin
            shift_ff <= {shift_ff[RES_W-2:0], tag_ff};
         end else if (ext_shift) begin
            shift_ff <= {shift_ff[RES_W-2:0], tag_s};
         end
      end
   end

   ///////////////////////////////////////////////////////////////////////////////
   // internal bit clock sequencer: delay, then 16 high/low pulses
   always_ff @(posedge clk) begin
      if (I_RESET) begin
         is_ff      <= IS_OFF;
         is_cnt_ff  <= '0;
         is_bits_ff <= '0;
         iclk_ff    <= 1'b0;
      end else if (I_CE) begin
         case (is_ff)
            IS_OFF: begin
               if (start && !src_s) begin
                  is_ff      <= IS_DELAY;
                  is_cnt_ff  <= '0;
                  is_bits_ff <= '0;
               end
            end
            IS_DELAY: begin
               if (conv_done) begin
                  is_ff <= IS_OFF;
               end else if (is_cnt_ff == CNT_W'(DELAY_CYCLES - 1)) begin
                  is_ff     <= IS_HIGH;
                  is_cnt_ff <= '0;
                  iclk_ff   <= 1'b1;
               end else begin
                  is_cnt_ff <= is_cnt_ff + 1'b1;
               end
            end
            IS_HIGH: begin
               if (conv_done) begin
                  is_ff   <= IS_OFF;
                  iclk_ff <= 1'b0;
               end else if (is_cnt_ff == CNT_W'(HALF_CYCLES - 1)) begin
                  is_ff     <= IS_LOW;
                  is_cnt_ff <= '0;
                  iclk_ff   <= 1'b0;
               end else begin
                  is_cnt_ff <= is_cnt_ff + 1'b1;
               end
            end
            IS_LOW: begin
               if (conv_done || (is_end && is_bits_ff == RES_BITS - 1'b1)) begin
                  is_ff <= IS_OFF;
               end else if (is_end) begin
                  is_ff      <= IS_HIGH;
                  is_cnt_ff  <= '0;
                  is_bits_ff <= is_bits_ff + 1'b1;
                  iclk_ff    <= 1'b1;
               end else begin
                  is_cnt_ff <= is_cnt_ff + 1'b1;
               end
            end
            default: begin
               is_ff <= IS_OFF;
            end
         endcase
      end
   end
   // chain level caught during the first pulse
   always_ff @(posedge clk) begin
      if (I_RESET) begin
         tag_ff <= 1'b0;
      end else if (I_CE && is_ff == IS_HIGH && is_bits_ff == '0) begin
         tag_ff <= tag_s;
      end
   end

   // bit clock pin driven only with internal source
   always_ff @(posedge clk) begin
      if (I_RESET) begin
         sbc_oe_n_ff <= 1'b1;
      end else if (I_CE) begin
         sbc_oe_n_ff <= src_s;
      end
   end

   ///////////////////////////////////////////////////////////////////////////////
   // parallel bus, reads leave the result untouched
   always_ff @(posedge clk) begin
      if (I_RESET) begin
         pbus_ff      <= '0;
         pbus_oe_n_ff <= 1'b1;
      end else if (I_CE) begin
         pbus_oe_n_ff <= !(!cs_n_s && rc_s);
         pbus_ff      <= byte_s ? result_ff[HALF_W-1:0]
                                : result_ff[RES_W-1:HALF_W];
      end
   end

   ///////////////////////////////////////////////////////////////////////////////
   // outputs
   assign LNK.busy_n       = busy_n_ff;
   assign LNK.serial_result_out        = shift_ff[RES_W-1];
   assign LNK.sbc_dev_o    = iclk_ff;
   assign LNK.sbc_dev_oe_n = sbc_oe_n_ff;
   assign LNK.pbus_o       = pbus_ff;
   assign LNK.pbus_oe_n    = pbus_oe_n_ff;
   assign O_RESULT_VALID   = valid_ff;
   assign O_CONVERTING     = !busy_n_ff;
endmodule
`default_nettype wire

/* File: core/sarr_pkg.sv */
// shared constants and types of the converter result readout
package sarr_pkg;
   // widths
   localparam int RES_W       = 16;
   localparam int HALF_W      = 8;
   localparam int CNT_W       = 16;
   localparam int BIT_CNT_W   = 5;
   localparam int SYNC_DEPTH  = 2;
   localparam logic [RES_W-1:0] SIGN_MASK = 16'h8000;
   localparam logic [RES_W-1:0] RES_RESET = 16'h0000;
   localparam logic [BIT_CNT_W-1:0] RES_BITS = 5'h10;

   // link side timing, link clock 12 ns
   localparam int LINK_CLK_NS    = 12;
   localparam int CONV_TIME_NS   = 18000;
   localparam int ICLK_DELAY_NS  = 2400;
   localparam int ICLK_PERIOD_NS = 820;
   localparam int CONV_CYC       = CONV_TIME_NS / LINK_CLK_NS;
   localparam int ICLK_DELAY_CYC = ICLK_DELAY_NS / LINK_CLK_NS;
   localparam int ICLK_HALF_CYC  = ICLK_PERIOD_NS / (2 * LINK_CLK_NS);

   // host side timing, host clock 4 ns
   localparam int HOST_CLK_NS    = 4;
   localparam int START_LOW_NS   = 40;
   localparam int BUS_ACCESS_NS  = 83;
   localparam int SYNC_MARGIN_NS = 80;
   localparam int EXT_HALF_NS    = 100;
   localparam int START_CYC  = (START_LOW_NS + HOST_CLK_NS - 1) / HOST_CLK_NS;
   localparam int SETTLE_CYC = (BUS_ACCESS_NS + SYNC_MARGIN_NS + HOST_CLK_NS - 1)
                               / HOST_CLK_NS;
   localparam int EXT_HALF_CYC = (EXT_HALF_NS + HOST_CLK_NS - 1) / HOST_CLK_NS;

   // device states
   typedef enum logic [0:0] {
      DV_IDLE = 1'b0,
      DV_CONV = 1'b1
   } sarr_dev_st_t;

   // internal bit clock sequencer states
   typedef enum logic [1:0] {
      IS_OFF   = 2'b00,
      IS_DELAY = 2'b01,
      IS_HIGH  = 2'b10,
      IS_LOW   = 2'b11
   } sarr_iser_st_t;

   // host states
   typedef enum logic [2:0] {
      HS_IDLE  = 3'b000,
      HS_START = 3'b001,
      HS_WLO   = 3'b010,
      HS_WHI   = 3'b011,
      HS_RDHI  = 3'b100,
      HS_RDLO  = 3'b101,
      HS_SER   = 3'b110,
      HS_DONE  = 3'b111
   } sarr_host_st_t;
endpackage

/* File: core/sarr_if.sv */
// pin level carrier between the converter and its host
`timescale 1ns/1ps
`default_nettype none
interface sarr_if;
   logic       link_clk;      // device clock, made by the bench
   logic       cs_n;
   logic       rc;            // high read, low convert
   logic       byte_sel;      // low upper half, high lower half
   logic       code_fmt;      // high unsigned_offset_code
   logic       clk_src;       // high external bit clock
   logic       tag;           // chain input
   logic       sbc_host_o;
   logic       sbc_host_oe_n;
   logic       sbc_dev_o;
   logic       sbc_dev_oe_n;
   logic       sbc;           // resolved serial_bit_clock
   logic       busy_n;
   logic       serial_result_out;         // serial_result_out
   logic [7:0] pbus_o;
   logic       pbus_oe_n;
   logic [7:0] pbus;          // resolved parallel_result_bus, pulled low

   // wire resolution from the enables
   assign sbc  = !sbc_dev_oe_n ? sbc_dev_o : (!sbc_host_oe_n ? sbc_host_o : 1'b0);
   assign pbus = !pbus_oe_n ? pbus_o : 8'h00;

   modport dev (
      input  link_clk, cs_n, rc, byte_sel, code_fmt, clk_src, tag, sbc,
      output sbc_dev_o, sbc_dev_oe_n, busy_n, serial_result_out, pbus_o, pbus_oe_n
   );
   modport host (
      input  busy_n, serial_result_out, pbus, sbc,
      output cs_n, rc, byte_sel, code_fmt, clk_src, tag, sbc_host_o, sbc_host_oe_n
   );
endinterface
`default_nettype wire

/* File: core/sarr_sync.sv */
// two flip-flop synchroniser for a group of levels
`timescale 1ns/1ps
`default_nettype none
module sarr_sync #(
   parameter int W = 1
) (
   input  wire logic         i_clk,
   input  wire logic         i_ce,
   input  wire logic [W-1:0] i_d,
   output logic      [W-1:0] o_q
);
   logic [W-1:0] meta_ff;

   // first stage feeds only the second
   always_ff @(posedge i_clk) begin
      if (i_ce) begin
         meta_ff <= i_d;
         o_q     <= meta_ff;
      end
   end
endmodule
`default_nettype wire

/* File: core/sarr_host.sv */
// host end: starts conversions and reads results over both ports
`timescale 1ns/1ps
`default_nettype none
module sarr_host
   import sarr_pkg::*;
#(
   parameter int START_CYCLES  = sarr_pkg::START_CYC,
   parameter int SETTLE_CYCLES = sarr_pkg::SETTLE_CYC,
   parameter int HALF_CYCLES   = sarr_pkg::EXT_HALF_CYC
) (
   sarr_if.host                            LNK,
   input  wire logic                       I_CLK,
   input  wire logic                       I_RESET,
   input  wire logic                       I_CE,
   input  wire logic                       I_START,
   input  wire logic                       I_EXT_CLK,
   input  wire logic                       I_FMT_SB,
   input  wire logic                       I_TAG,
   output logic                            O_BUSY,
   output logic                            O_DONE,
   output logic [sarr_pkg::RES_W-1:0]      O_PAR_WORD,
   output logic [sarr_pkg::RES_W-1:0]      O_SER_WORD
);
   import sarr_pkg::*;

   ///////////////////////////////////////////////////////////////////////////////
   // declarations
   logic [10:0]          pins_s;
   logic                 busy_n_s;
   logic                 serial_result_out_s;
   logic                 sbc_s;
   logic [HALF_W-1:0]    pbus_s;
   logic                 sbc_prev_ff;
   sarr_host_st_t        st_ff;
   logic [CNT_W-1:0]     cnt_ff;
   logic [BIT_CNT_W-1:0] bits_ff;
   logic                 ext_ff;
   logic                 fmt_ff;
   logic                 cs_n_ff;
   logic                 rc_ff;
   logic                 byte_ff;
   logic                 hclk_ff;
   logic                 done_ff;
   logic                 tag_ff;
   logic [RES_W-1:0]     par_ff;
   logic [RES_W-1:0]     ser_ff;
   logic                 cnt_end;

   // device pins cross into the host clock
   sarr_sync #(.W(11)) u_sync (
      .i_clk (I_CLK),
      .i_ce  (I_CE),
      .i_d   ({LNK.busy_n, LNK.serial_result_out, LNK.sbc, LNK.pbus}),
      .o_q   (pins_s)
   );
   assign {busy_n_s, serial_result_out_s, sbc_s, pbus_s} = pins_s;

   always_ff @(posedge I_CLK) begin
      if (I_RESET) begin
         sbc_prev_ff <= 1'b0;
         tag_ff      <= 1'b0;
      end else if (I_CE) begin
         sbc_prev_ff <= sbc_s;
         tag_ff      <= I_TAG;
      end
   end

   assign cnt_end = (st_ff == HS_START) ? (cnt_ff == CNT_W'(START_CYCLES - 1)) :
                    (st_ff == HS_SER)   ? (cnt_ff == CNT_W'(HALF_CYCLES - 1))  :
                                          (cnt_ff == CNT_W'(SETTLE_CYCLES - 1));

   ///////////////////////////////////////////////////////////////////////////////
   // sequence: start, wait busy, read parallel, then optional external serial
   always_ff @(posedge I_CLK) begin
      if (I_RESET) begin
         st_ff   <= HS_IDLE;
         cnt_ff  <= '0;
         bits_ff <= '0;
         ext_ff  <= 1'b1;
         fmt_ff  <= 1'b0;
         cs_n_ff <= 1'b1;
         rc_ff   <= 1'b1;
         byte_ff <= 1'b0;
         hclk_ff <= 1'b0;
         done_ff <= 1'b0;
         par_ff  <= RES_RESET;
         ser_ff  <= RES_RESET;
      end else if (I_CE) begin
         done_ff <= 1'b0;
         cnt_ff  <= cnt_end ? '0 : cnt_ff + 1'b1;
         case (st_ff)
            HS_IDLE: begin
               cnt_ff <= '0;
               if (I_START) begin
                  st_ff   <= HS_START;
                  ext_ff  <= I_EXT_CLK;
                  fmt_ff  <= I_FMT_SB;
                  cs_n_ff <= 1'b0;
                  rc_ff   <= 1'b0;
                  bits_ff <= '0;
               end
            end
            HS_START: begin
               if (cnt_end) begin
                  st_ff   <= HS_WLO;
                  cs_n_ff <= 1'b1;
                  rc_ff   <= 1'b1;
               end
            end
            HS_WLO: begin
               cnt_ff <= '0;
               if (!busy_n_s) begin
                  st_ff <= HS_WHI;
               end
            end
            HS_WHI: begin
               cnt_ff <= '0;
               if (!ext_ff && sbc_s && !sbc_prev_ff) begin
                  ser_ff <= {ser_ff[RES_W-2:0], serial_result_out_s};
               end
               if (busy_n_s) begin
                  st_ff   <= HS_RDHI;
                  cs_n_ff <= 1'b0;
                  byte_ff <= 1'b0;
               end
            end
            HS_RDHI: begin
               if (cnt_end) begin
                  par_ff[RES_W-1:HALF_W] <= pbus_s;
                  byte_ff <= 1'b1;
                  st_ff   <= HS_RDLO;
               end
            end
            HS_RDLO: begin
               if (cnt_end) begin
                  par_ff[HALF_W-1:0] <= pbus_s;
                  byte_ff <= 1'b0;
                  st_ff   <= ext_ff ? HS_SER : HS_DONE;
               end
            end
            HS_SER: begin
               if (cnt_end && !hclk_ff) begin
                  ser_ff  <= {ser_ff[RES_W-2:0], serial_result_out_s};
                  hclk_ff <= 1'b1;
                  bits_ff <= bits_ff + 1'b1;
               end else if (cnt_end) begin
                  hclk_ff <= 1'b0;
                  if (bits_ff == RES_BITS) begin
                     st_ff <= HS_DONE;
                  end
               end
            end
            HS_DONE: begin
               cs_n_ff <= 1'b1;
               done_ff <= 1'b1;
               st_ff   <= HS_IDLE;
            end
            default: begin
               st_ff <= HS_IDLE;
            end
         endcase
      end
   end

   ///////////////////////////////////////////////////////////////////////////////
   // pins; external clock held low outside reads
   assign LNK.cs_n          = cs_n_ff;
   assign LNK.rc            = rc_ff;
   assign LNK.byte_sel      = byte_ff;
   assign LNK.code_fmt      = fmt_ff;
   assign LNK.clk_src       = ext_ff;
   assign LNK.tag           = tag_ff;
   assign LNK.sbc_host_o    = hclk_ff;
   assign LNK.sbc_host_oe_n = !ext_ff;
   assign O_BUSY            = (st_ff != HS_IDLE);
   assign O_DONE            = done_ff;
   assign O_PAR_WORD        = par_ff;
   assign O_SER_WORD        = ser_ff;
endmodule
`default_nettype wire

/* File: testbench/sarr_checker.sv */
// concurrent checks on the pins between converter and host
`timescale 1ns/1ps
`default_nettype none
module sarr_checker #(
   parameter int CONV_CYCLES = 200
) (
   input  wire logic       link_clk,
   input  wire logic       I_RESET,
   input  wire logic       cs_n,
   input  wire logic       rc,
   input  wire logic       byte_sel,
   input  wire logic       clk_src,
   input  wire logic       sbc,
   input  wire logic       sbc_dev_o,
   input  wire logic       sbc_dev_oe_n,
   input  wire logic       busy_n,
   input  wire logic       serial_result_out,
   input  wire logic [7:0] pbus_o,
   input  wire logic       pbus_oe_n
);
   logic [15:0] low_cnt_ff;
   logic [4:0]  pulse_cnt_ff;
   logic [3:0]  age_ff;

   default clocking cb @(posedge link_clk);
   endclocking
   default disable iff (I_RESET);

   ////////////////////////////////////////////////////////////////////////////
   // length of each busy period
   always_ff @(posedge link_clk) begin
      low_cnt_ff <= (I_RESET || busy_n) ? 16'h0000 : low_cnt_ff + 16'h0001;
   end

   // internal bit clock pulses since the conversion began
   always_ff @(posedge link_clk) begin
      if (I_RESET || $fell(busy_n)) begin
         pulse_cnt_ff <= 5'h00;
      end else if (!sbc_dev_oe_n && $rose(sbc_dev_o)) begin
         pulse_cnt_ff <= pulse_cnt_ff + 5'h01;
      end
   end

   // cycles since both strobes were last low together
   always_ff @(posedge link_clk) begin
      if (I_RESET || (!cs_n && !rc)) begin
         age_ff <= 4'h0;
      end else if (age_ff != 4'hF) begin
         age_ff <= age_ff + 4'h1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   bus_unselected_a: assert property (cs_n [*5] |-> pbus_oe_n)
      else $error("bus driven while unselected");
   bus_convert_a: assert property ((!rc) [*2] |-> ##2 pbus_oe_n)
      else $error("bus driven in convert mode");
   busy_length_a: assert property ($rose(busy_n) |-> low_cnt_ff == CONV_CYCLES)
      else $error("busy period length wrong");
   start_cause_a: assert property ($fell(busy_n) |-> age_ff <= 4'h6)
      else $error("busy fell without a start");
   read_keeps_a: assert property ((busy_n && !sbc && !pbus_oe_n && $stable(byte_sel)) [*8]
      |-> $stable(pbus_o))
      else $error("parallel data changed during read");
   pulse_count_a: assert property ($rose(busy_n) && !sbc_dev_oe_n && !clk_src
      |-> pulse_cnt_ff == 5'h10)
      else $error("internal pulse count wrong");
   clock_rest_a: assert property (busy_n |-> !(!sbc_dev_oe_n && sbc_dev_o))
      else $error("internal clock high between conversions");
   data_steady_a: assert property (!sbc_dev_oe_n && $changed(sbc) |-> $stable(serial_result_out))
      else $error("serial data moved on a clock edge");
   ext_input_a: assert property (clk_src [*5] |-> sbc_dev_oe_n)
      else $error("bit clock driven in external mode");

   cv_done: cover property ($rose(busy_n));
   cv_read: cover property ($fell(pbus_oe_n));
   cv_ext: cover property (sbc_dev_oe_n && $rose(sbc));
   cv_int: cover property (!sbc_dev_oe_n && $rose(sbc));
endmodule
`default_nettype wire

/* File: testbench/sar_adc_result_readout_tb.sv */
// self-checking bench: host end and converter end joined over the link
`timescale 1ns/1ps
`default_nettype none
module sar_adc_result_readout_tb;
   import sarr_pkg::*;
   localparam int CONV = 200;
   logic             clk = 1'b0;
   logic             rst = 1'b1;
   logic             start = 1'b0;
   logic             ext = 1'b0;
   logic             fmt = 1'b0;
   logic             tag = 1'b0;
   logic [RES_W-1:0] smp = 16'h0000;
   logic             valid;
   logic             done;
   logic             busy_h;
   logic             conv_d;
   logic [RES_W-1:0] par_w;
   logic [RES_W-1:0] ser_w;
   logic [RES_W-1:0] sr_m;
   logic             sr_ok = 1'b0;
   int               err_total = 0;
   int               comparisons = 0;
   logic [RES_W-1:0] pts [4] = '{16'hFFFF, 16'h8000, 16'h7FFF, 16'h0000};
   logic [RES_W-1:0] tcs [4] = '{16'h7FFF, 16'h0000, 16'hFFFF, 16'h8000};

   ////////////////////////////////////////////////////////////////////////////
   // clocks, link clock free of the host clock phase
   always #2 clk = ~clk;
   sarr_if sarr_if_inst ();
   initial begin
      sarr_if_inst.link_clk = 1'b0;
      #1.7;
      forever #6 sarr_if_inst.link_clk = ~sarr_if_inst.link_clk;
   end

   sarr_dev #(.CONV_CYCLES(CONV), .DELAY_CYCLES(4), .HALF_CYCLES(3)) sarr_dev_inst (
      .LNK            (sarr_if_inst.dev),
      .I_RESET        (rst),
      .I_CE           (1'b1),
      .I_SAMPLE       (smp),
      .O_RESULT_VALID (valid),
      .O_CONVERTING   (conv_d)
   );
   sarr_host sarr_host_inst (
      .LNK        (sarr_if_inst.host),
      .I_CLK      (clk),
      .I_RESET    (rst),
      .I_CE       (1'b1),
      .I_START    (start),
      .I_EXT_CLK  (ext),
      .I_FMT_SB   (fmt),
      .I_TAG      (tag),
      .O_BUSY     (busy_h),
      .O_DONE     (done),
      .O_PAR_WORD (par_w),
      .O_SER_WORD (ser_w)
   );
   sarr_checker #(.CONV_CYCLES(CONV)) sarr_checker_inst (
      .link_clk     (sarr_if_inst.link_clk),
      .I_RESET      (rst),
      .cs_n         (sarr_if_inst.cs_n),
      .rc           (sarr_if_inst.rc),
      .byte_sel     (sarr_if_inst.byte_sel),
      .clk_src      (sarr_if_inst.clk_src),
      .sbc          (sarr_if_inst.sbc),
      .sbc_dev_o    (sarr_if_inst.sbc_dev_o),
      .sbc_dev_oe_n (sarr_if_inst.sbc_dev_oe_n),
      .busy_n       (sarr_if_inst.busy_n),
      .serial_result_out        (sarr_if_inst.serial_result_out),
      .pbus_o       (sarr_if_inst.pbus_o),
      .pbus_oe_n    (sarr_if_inst.pbus_oe_n)
   );

   ////////////////////////////////////////////////////////////////////////////
   // compare, count, report
   task automatic check(input logic [RES_W-1:0] seen, input logic [RES_W-1:0] exp);
      comparisons++;
      if (seen !== exp) begin
         err_total++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // expected output code from an offset binary sample
   function automatic logic [RES_W-1:0] code(input logic [RES_W-1:0] s, input logic sb);
      return sb ? s : (s ^ 16'h8000);
   endfunction

   // one conversion: internal serial during it then parallel read, or parallel read then external serial
   task automatic run(input logic [RES_W-1:0] s, input logic sb, input logic x,
                      input logic tg, input logic [RES_W-1:0] e);
      int n;
      smp <= s;
      fmt <= sb;
      ext <= x;
      tag <= tg;
      repeat (5) @(posedge clk);
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      repeat (40) @(negedge clk);
      check({14'h0000, busy_h, conv_d}, 16'h0003);
      for (n = 0; n < 4000 && done !== 1'b1; n++) @(negedge clk);
      check({15'h0000, done}, 16'h0001);
      check(par_w, e);
      if (x) begin
         check(ser_w, e);
      end else if (sr_ok) begin
         check(ser_w, sr_m);
      end
      check({15'h0000, valid}, 16'h0001);
      check({14'h0000, busy_h, conv_d}, 16'h0000);
      sr_m = x ? {16{tg}} : e;
      sr_ok = 1'b1;
      repeat (10) @(posedge clk);
      check({7'h00, sarr_if_inst.pbus_oe_n, sarr_if_inst.pbus}, 16'h0100);
   endtask

   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // watchdog
   initial begin
      #300000;
      err_total++;
      end_sim();
   end

   // code points in both formats, then random traffic
   initial begin
      int               i;
      logic [RES_W-1:0] s;
      logic             b;
      void'($urandom(32'h67b7bbb9));
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      for (i = 0; i < 4; i++) begin
         run(pts[i], 1'b0, i[0], 1'b1, tcs[i]);
         run(pts[i], 1'b1, !i[0], 1'b0, pts[i]);
      end
      for (i = 0; i < 12; i++) begin
         s = 16'($urandom);
         b = 1'($urandom);
         run(s, b, 1'($urandom), 1'($urandom), code(s, b));
      end
      end_sim();
   end
endmodule
`default_nettype wire
